/* rtl/sir_readout_top.sv */
// rolling-shutter sensor readout: row sequencer, pixel chain, fifo, output port
`timescale 1ns/1ns
`include "sir_defines.svh"

// pixel pair fifo with valid and ready on both sides
module sir_fifo #(
  parameter int W = 29,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  // full when indexes match and wrap bits differ
  assign in_ready = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data = mem[rd_ptr[AW-1:0]];
  // pointers
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
    end
  end
  // storage
  always_ff @(posedge ref_clk)
  begin
    if (push) mem[wr_ptr[AW-1:0]] <= in_data;
  end
endmodule

// Overview of operation
// - timing from master clock, or from ref_clk divider when pll on
// - output rate capped at output maximum when pll on
// - fixed frame length, constant frame rate
// - rows reset then read, in order
// - exposure equals reset to read row distance
// - analog offset and gain before converter
// - one 12-bit converter result per pixel
// - black correction and digital gain applied
// - hdr emits two exposures; receiver merges them
// - address 0x20 or 0x30 by select pin
// - async low reset restores default settings
// - serial lanes, ddr clock and shutter driven only while enable low; parallel port always driven
// - mechanical shutter output, may float
// - four serial lanes plus ddr clock
// - default 1080 lines, 60 fps, serial
// - parallel mode frame, line markers, pixel clock
module sir_readout_top (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // pins from outside the clock domain
  input wire logic master_input_clock,
  input wire logic bus_address_select,
  input wire logic output_enable_n,
  // two-wire address check
  input wire logic [7:0] bus_addr_byte,
  output logic bus_addr_hit,
  // settings from the two-wire register file
  input wire sir_pkg::sir_cfg_s cfg_in,
  input wire logic cfg_load,
  // array and converter
  output logic row_reset,
  output logic row_read,
  output logic row_t2,
  output logic [11:0] row_reset_addr,
  output logic [11:0] row_read_addr,
  output logic [7:0] analog_gain,
  output logic [11:0] analog_offset,
  input wire logic [11:0] adc_data,
  input wire logic adc_valid,
  output logic adc_ready,
  // serial port
  output logic [3:0] serial_lane_pos,
  output logic [3:0] serial_lane_neg,
  output logic serial_ddr_clock_pos,
  output logic serial_ddr_clock_neg,
  output logic driver_high_common_mode,
  // parallel port
  output logic [11:0] par_data,
  output logic pixel_clock,
  output logic frame_valid,
  output logic line_valid,
  output logic line_is_t2,
  // mechanical shutter
  output logic shutter
);
  import sir_pkg::*;
  localparam sir_cfg_s CFG_RST = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, `SIR_FRAME_ROWS,
    `SIR_ACTIVE_ROWS, `SIR_LINE_PIXELS, `SIR_ROW_TICKS, `SIR_EXPO_ROWS, `SIR_T2_ROWS,
    `SIR_AGAIN_ONE, `SIR_OFFSET_DEF, `SIR_BLACK_DEF, `SIR_DGAIN_ONE};
  localparam logic [1:0] PLL_LAST = 2'(`SIR_PLL_DIV - 1);

  // row index plus distance, folded into the frame
  function automatic logic [11:0] wrap_row(input logic [11:0] r, input logic [11:0] d,
                                           input logic [11:0] n);
    logic [12:0] s;
    s = {1'b0, r} + {1'b0, d};
    if (s >= {1'b0, n}) s = s - {1'b0, n};
    wrap_row = s[11:0];
  endfunction

  // black level subtract, digital gain, clip to 12 bits
  function automatic logic [11:0] dig_chain(input logic [11:0] v, input logic [11:0] blk,
                                            input logic [7:0] g);
    logic [11:0] c;
    logic [19:0] p;
    c = (v > blk) ? v - blk : 12'h000;
    p = 20'(c) * 20'(g);
    p = p >> `SIR_DGAIN_FRAC;
    dig_chain = (p > 20'h00fff) ? 12'hfff : p[11:0];
  endfunction

  sir_cfg_s cfg;
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic mclk_prev;
  logic [1:0] pll_cnt;
  logic [1:0] warm;
  logic addr_taken;
  logic addr_sel;
  logic [11:0] tick_cnt;
  logic [11:0] row_cnt;
  logic line_open;
  logic line_t2;
  logic line_first;
  logic line_last;
  logic [11:0] col_cnt;
  logic have_a;
  logic [11:0] pend_a;
  sir_out_e out_state;
  sir_pair_s shreg;
  logic [2:0] bit_cnt;
  logic [3:0] lane_bit;
  logic ddr_clk;
  logic drive;
  logic in_rows;

  // async reset to defaults, load from register file
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn) cfg <= CFG_RST;
    else if (cfg_load) cfg <= cfg_in;
  end
  assign analog_gain = cfg.analog_gain;
  assign analog_offset = cfg.analog_offset;
  assign driver_high_common_mode = cfg.driver_high_common_mode;

  // two-flop synchronisers: 0 master clock, 1 address select, 2 enable
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h4;
      mclk_prev <= 1'b0;
    end
    else
    begin
      pin_meta <= {output_enable_n, bus_address_select, master_input_clock};
      pin_sync <= pin_meta;
      mclk_prev <= pin_sync[0];
    end
  end

  // pixel tick from master clock edge or pll divider
  wire mclk_rise = pin_sync[0] && !mclk_prev;
  wire pll_tick = (pll_cnt == PLL_LAST);
  wire tick = cfg.pll_enable ? pll_tick : mclk_rise;
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn) pll_cnt <= 2'h0;
    else pll_cnt <= pll_tick ? 2'h0 : pll_cnt + 2'h1;
  end

  // address select caught once the synchroniser has settled
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      warm <= 2'h0;
      addr_taken <= 1'b0;
      addr_sel <= 1'b0;
    end
    else
    begin
      if (warm != 2'h3) warm <= warm + 2'h1;
      if (warm == 2'h2 && !addr_taken)
      begin
        addr_sel <= pin_sync[1];
        addr_taken <= 1'b1;
      end
    end
  end
  wire [7:0] my_addr = addr_sel ? `SIR_ADDR_HIGH : `SIR_ADDR_LOW;
  assign bus_addr_hit = addr_taken && (bus_addr_byte[7:1] == my_addr[7:1]);

  // row slot timing; frame length never changes with content
  wire slot_start = tick && (tick_cnt == 12'h000);
  wire half_start = tick && cfg.hdr_enable && (tick_cnt == {1'b0, cfg.row_ticks[11:1]});
  wire row_end = tick && (tick_cnt == cfg.row_ticks - 12'h001);
  wire frame_end = (row_cnt == cfg.frame_rows - 12'h001);
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tick_cnt <= 12'h000;
      row_cnt <= 12'h000;
    end
    else if (row_end)
    begin
      tick_cnt <= 12'h000;
      row_cnt <= frame_end ? 12'h000 : row_cnt + 12'h001;
    end
    else if (tick) tick_cnt <= tick_cnt + 12'h001;
  end

  // reset pointer leads read pointer by the exposure distance
  wire [11:0] rst1_row = wrap_row(row_cnt, cfg.exposure_rows, cfg.frame_rows);
  wire [11:0] rst2_row = wrap_row(row_cnt, cfg.t2_rows, cfg.frame_rows);
  wire row_active = (row_cnt < cfg.active_rows);
  wire [11:0] next_rst_row = half_start ? rst2_row : rst1_row;
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      row_reset <= 1'b0;
      row_read <= 1'b0;
      row_t2 <= 1'b0;
      row_reset_addr <= 12'h000;
      row_read_addr <= 12'h000;
    end
    else
    begin
      row_reset <= (slot_start || half_start) && (next_rst_row < cfg.active_rows);
      row_read <= (slot_start || half_start) && row_active;
      row_t2 <= half_start;
      row_reset_addr <= next_rst_row;
      row_read_addr <= row_cnt;
    end
  end

  // converter intake: one 12-bit sample per column, paired
  sir_pair_s fifo_in;
  sir_pair_s fifo_out;
  logic fifo_in_ready;
  logic fifo_out_valid;
  wire [11:0] pix_now = dig_chain(adc_data, cfg.black_level, cfg.digital_gain);
  wire col_last = (col_cnt == cfg.line_pixels - 12'h001);
  wire fifo_in_valid = line_open && adc_valid && have_a;
  assign adc_ready = line_open && (!have_a || fifo_in_ready);
  assign fifo_in = '{line_first && col_cnt == 12'h001, line_last && col_last,
                     col_cnt == 12'h001, col_last, line_t2, pix_now, pend_a};
  wire take = adc_valid && adc_ready;
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      line_open <= 1'b0;
      line_t2 <= 1'b0;
      line_first <= 1'b0;
      line_last <= 1'b0;
      col_cnt <= 12'h000;
      have_a <= 1'b0;
      pend_a <= 12'h000;
    end
    else if (row_read)
    begin
      line_open <= 1'b1;
      line_t2 <= row_t2;
      line_first <= (row_read_addr == 12'h000) && !row_t2;
      line_last <= (row_read_addr == cfg.active_rows - 12'h001) && (row_t2 || !cfg.hdr_enable);
      col_cnt <= 12'h000;
      have_a <= 1'b0;
    end
    else if (take)
    begin
      col_cnt <= col_cnt + 12'h001;
      have_a <= !have_a;
      if (!have_a) pend_a <= pix_now;
      if (have_a && col_last) line_open <= 1'b0;
    end
  end

  // engine takes a pair on an idle tick; declared ahead of the fifo that reads it
  wire idle_tick = (out_state == OUT_IDLE) && tick;
  wire out_pop = idle_tick && fifo_out_valid;
  sir_fifo #(.W($bits(sir_pair_s)), .DEPTH(8)) u_fifo (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(out_pop),
    .out_data(fifo_out)
  );

  // output engine: serial 6 bits per lane, parallel 2 ticks per pixel
  wire [2:0] last_bit = cfg.parallel_mode ? 3'h3 : 3'(`SIR_LANE_BITS - 1);
  wire pair_done = (out_state == OUT_SHIFT) && tick && (bit_cnt == last_bit);
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      out_state <= OUT_IDLE;
      shreg <= '0;
      bit_cnt <= 3'h0;
    end
    else
    begin
      case (out_state)
        OUT_IDLE:
        begin
          if (out_pop)
          begin
            shreg <= fifo_out;
            bit_cnt <= 3'h0;
            out_state <= OUT_SHIFT;
          end
        end
        OUT_SHIFT:
        begin
          if (pair_done) out_state <= OUT_IDLE;
          else if (tick) bit_cnt <= bit_cnt + 3'h1;
        end
        default: out_state <= OUT_IDLE;
      endcase
    end
  end

  // lane bits, ddr clock, markers and enable, all registered
  wire shifting = (out_state == OUT_SHIFT) && tick;
  wire [23:0] pair_bits = {shreg.pix_b, shreg.pix_a};
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lane_bit <= 4'h0;
      ddr_clk <= 1'b0;
      drive <= 1'b0;
      in_rows <= 1'b0;
      frame_valid <= 1'b0;
      line_valid <= 1'b0;
      line_is_t2 <= 1'b0;
      par_data <= 12'h000;
      pixel_clock <= 1'b0;
    end
    else
    begin
      drive <= !pin_sync[2];
      in_rows <= row_active && cfg.shutter_enable;
      if (shifting && !cfg.parallel_mode)
      begin
        for (int l = 0; l < `SIR_LANES; l++)
          lane_bit[l] <= pair_bits[l*`SIR_LANE_BITS + 5 - int'(bit_cnt)];
        ddr_clk <= !ddr_clk;
      end
      if (shifting && cfg.parallel_mode)
      begin
        par_data <= bit_cnt[1] ? shreg.pix_b : shreg.pix_a;
        pixel_clock <= bit_cnt[0];
      end
      // markers drop one tick after the last pixel clock rise, so it stays inside them
      if (idle_tick && shreg.eol) line_valid <= 1'b0;
      if (idle_tick && shreg.eof) frame_valid <= 1'b0;
      if (out_pop)
      begin
        line_is_t2 <= fifo_out.t2;
        if (fifo_out.sof) frame_valid <= 1'b1;
        if (fifo_out.sol) line_valid <= 1'b1;
      end
    end
  end

  // serial pins gated by output enable and port mode, shutter by output enable
  wire ser_on = drive && !cfg.parallel_mode;
  assign serial_lane_pos = ser_on ? lane_bit : 4'h0;
  assign serial_lane_neg = ser_on ? ~lane_bit : 4'h0;
  assign serial_ddr_clock_pos = ser_on && ddr_clk;
  assign serial_ddr_clock_neg = ser_on && !ddr_clk;
  assign shutter = drive && in_rows;

  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  sequence s_last_slot;
    row_end && frame_end;
  endsequence
  property p_tick_src;
    !cfg.pll_enable && $stable(pin_sync[0]) |-> !tick;
  endproperty
  a_tick_src: assert property (p_tick_src) else $error("tick without clock edge");
  property p_frame_wrap;
    s_last_slot |=> row_cnt == 12'h000 && tick_cnt == 12'h000;
  endproperty
  a_frame_wrap: assert property (p_frame_wrap) else $error("frame length drifted");
  property p_read_row;
    slot_start |=> row_read == ($past(row_cnt) < cfg.active_rows) && !row_t2;
  endproperty
  a_read_row: assert property (p_read_row) else $error("row read missed");
  property p_expo;
    slot_start |=> row_reset_addr == wrap_row(row_read_addr, cfg.exposure_rows,
                                               cfg.frame_rows);
  endproperty
  a_expo: assert property (p_expo) else $error("exposure distance wrong");
  property p_unity;
    fifo_in_valid && cfg.digital_gain == `SIR_DGAIN_ONE && cfg.black_level == 12'h000
      |-> fifo_in.pix_b == adc_data;
  endproperty
  a_unity: assert property (p_unity) else $error("unity gain altered pixel");
  property p_addr_low;
    addr_taken && !addr_sel && bus_addr_byte[7:1] == `SIR_ADDR_LOW >> 1 |-> bus_addr_hit;
  endproperty
  a_addr_low: assert property (p_addr_low) else $error("low address not matched");
  property p_addr_hold;
    addr_taken |=> $stable(addr_sel) [*2];
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address changed");
  property p_oe_off;
    pin_sync[2] |=> serial_lane_pos == 4'h0 && serial_lane_neg == 4'h0 && !shutter;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("driven while disabled");
  property p_line_start;
    $rose(line_valid) |-> $past(fifo_out.sol) && $past(out_pop);
  endproperty
  a_line_start: assert property (p_line_start) else $error("line marker rose early");
  property p_eol_hold;
    pair_done && shreg.eol |=> line_valid;
  endproperty
  a_eol_hold: assert property (p_eol_hold) else $error("line marker left last pixel");
endmodule

/* rtl/sir_defines.svh */
// constants for the image sensor readout block
`ifndef SIR_DEFINES_SVH
`define SIR_DEFINES_SVH
`define SIR_PIX_W 12
`define SIR_LANES 4
`define SIR_LANE_BITS 6
`define SIR_ADDR_LOW 8'h20
`define SIR_ADDR_HIGH 8'h30
`define SIR_REF_CLK_HZ 125000000
`define SIR_OUT_CLK_MAX_HZ 74250000
`define SIR_PLL_DIV ((`SIR_REF_CLK_HZ + `SIR_OUT_CLK_MAX_HZ - 1) / `SIR_OUT_CLK_MAX_HZ)
`define SIR_FRAME_ROWS 12'd1125
`define SIR_ACTIVE_ROWS 12'd1080
`define SIR_LINE_PIXELS 12'd1920
`define SIR_ROW_TICKS 12'd1100
`define SIR_EXPO_ROWS 12'd1000
`define SIR_T2_ROWS 12'd125
`define SIR_AGAIN_ONE 8'h10
`define SIR_DGAIN_ONE 8'h20
`define SIR_DGAIN_FRAC 5
`define SIR_OFFSET_DEF 12'h000
`define SIR_BLACK_DEF 12'h0a8
`endif

/* rtl/sir_pkg.sv */
// types for the image sensor readout block
package sir_pkg;
  typedef struct packed {
    logic pll_enable;
    logic hdr_enable;
    logic parallel_mode;
    logic shutter_enable;
    logic driver_high_common_mode;
    logic [11:0] frame_rows;
    logic [11:0] active_rows;
    logic [11:0] line_pixels;
    logic [11:0] row_ticks;
    logic [11:0] exposure_rows;
    logic [11:0] t2_rows;
    logic [7:0] analog_gain;
    logic [11:0] analog_offset;
    logic [11:0] black_level;
    logic [7:0] digital_gain;
  } sir_cfg_s;
  typedef struct packed {
    logic sof;
    logic eof;
    logic sol;
    logic eol;
    logic t2;
    logic [11:0] pix_b;
    logic [11:0] pix_a;
  } sir_pair_s;
  typedef enum logic {OUT_IDLE, OUT_SHIFT} sir_out_e;
endpackage

/* dv/sir_isp_model.sv */
// receiving image processor model: serial deserialiser and parallel capture
`timescale 1ns/1ns
module sir_isp_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // receiver mode and pin enable
  input wire logic par_mode,
  input wire logic output_enable_n,
  // serial lanes and ddr clock
  input wire logic [3:0] lane_p,
  input wire logic [3:0] lane_n,
  input wire logic clk_p,
  input wire logic clk_n,
  // parallel port
  input wire logic [11:0] par_data,
  input wire logic pixel_clock,
  input wire logic frame_valid,
  input wire logic line_valid,
  input wire logic line_is_t2,
  // received pairs and counts
  output logic [23:0] word,
  output logic word_stb,
  output int bad_cnt,
  output int t2_cnt
);
  logic clk_q;
  logic pclk_q;
  logic half;
  int bit_n;
  // a bit on every ddr clock toggle, a pixel on every pixel clock rise
  always @(posedge ref_clk)
  begin
    word_stb = 1'b0;
    if (!rstn)
    begin
      clk_q = 1'b0;
      pclk_q = 1'b0;
      half = 1'b0;
      bit_n = 0;
      bad_cnt = 0;
      t2_cnt = 0;
      word = '0;
    end
    else if (!output_enable_n)
    begin
      // lane l holds bits l*6+5 down to l*6, msb first
      if (!par_mode && clk_p != clk_q)
      begin
        for (int l = 0; l < 4; l++)
          word[l * 6 + 5 - bit_n] = lane_p[l];
        if (lane_n !== ~lane_p || clk_n !== ~clk_p)
          bad_cnt++;
        word_stb = (bit_n == 5);
        bit_n = (bit_n == 5) ? 0 : bit_n + 1;
      end
      // pix_a then pix_b, both inside frame and line markers
      if (par_mode && pixel_clock && !pclk_q)
      begin
        if (half)
          word[23:12] = par_data;
        else
          word[11:0] = par_data;
        word_stb = half;
        half = !half;
        if (!(frame_valid && line_valid))
          bad_cnt++;
        if (line_is_t2)
          t2_cnt++; // second exposure kept apart for merging
      end
      clk_q = clk_p;
      pclk_q = pixel_clock;
    end
  end
endmodule

/* dv/sir_readout_top_test.sv */
// self-checking bench for the sensor readout block
`timescale 1ns/1ns
`include "sir_defines.svh"
module sir_readout_top_test;
  import sir_pkg::*;
  logic ref_clk, rstn, master_input_clock, bus_address_select, output_enable_n;
  logic [7:0] bus_addr_byte;
  logic bus_addr_hit, cfg_load, row_reset, row_read, row_t2, adc_valid, adc_ready;
  sir_cfg_s cfg_in;
  logic [11:0] row_reset_addr, row_read_addr, analog_offset, adc_data, par_data;
  logic [7:0] analog_gain;
  logic [3:0] serial_lane_pos, serial_lane_neg;
  logic serial_ddr_clock_pos, serial_ddr_clock_neg, driver_high_common_mode;
  logic pixel_clock, frame_valid, line_valid, line_is_t2, shutter;
  logic par_mode, adc_en, take, mon_en, have_prev, shut_seen, word_stb;
  logic [23:0] word;
  logic [11:0] sent[$];
  logic [23:0] got[$];
  int bad_cnt, t2_cnt, prev, gap, slot, t2_reads, error_cnt, samples_checked;
  sir_readout_top i_dut (.ref_clk, .rstn, .master_input_clock, .bus_address_select,
    .output_enable_n, .bus_addr_byte, .bus_addr_hit, .cfg_in, .cfg_load, .row_reset,
    .row_read, .row_t2, .row_reset_addr, .row_read_addr, .analog_gain, .analog_offset,
    .adc_data, .adc_valid, .adc_ready, .serial_lane_pos, .serial_lane_neg,
    .serial_ddr_clock_pos, .serial_ddr_clock_neg, .driver_high_common_mode, .par_data,
    .pixel_clock, .frame_valid, .line_valid, .line_is_t2, .shutter);
  sir_isp_model i_isp (.ref_clk, .rstn, .par_mode, .output_enable_n,
    .lane_p(serial_lane_pos), .lane_n(serial_lane_neg), .clk_p(serial_ddr_clock_pos),
    .clk_n(serial_ddr_clock_neg), .par_data, .pixel_clock, .frame_valid, .line_valid,
    .line_is_t2, .word, .word_stb, .bad_cnt, .t2_cnt);
  // system clock and a free-running master clock of unrelated phase
  initial
  begin
    ref_clk = 0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial
  begin
    master_input_clock = 0;
    #3;
    forever #80 master_input_clock = ~master_input_clock;
  end
  // expected pixel after black level, gain and clipping
  function automatic logic [11:0] proc(input logic [11:0] v);
    logic [19:0] p;
    p = (v < cfg_in.black_level) ? 20'h0 : 20'(v - cfg_in.black_level) * cfg_in.digital_gain;
    p = p >> `SIR_DGAIN_FRAC;
    return (p > 20'hfff) ? 12'hfff : p[11:0];
  endfunction
  task automatic cmp(input string nm, input logic [23:0] e, input logic [23:0] g);
    samples_checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_n(input string nm, input int e, input int g);
    samples_checked++;
    if (g != e)
    begin
      error_cnt++;
      $display("Error %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic complete_run();
    if (error_cnt == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // converter feed: a sample counts once the design took it
  always @(negedge ref_clk)
  begin
    if (take)
    begin
      sent.push_back(adc_data);
      adc_data = 12'(sent.size() * 12'h2c9 + 12'h007);
    end
    adc_valid = adc_en;
    take = adc_valid && adc_ready;
    if (word_stb)
      got.push_back(word);
  end
  // row sequencer watch: order, slot length, reset-to-read distance
  always @(negedge ref_clk)
  begin
    gap++;
    shut_seen |= shutter;
    if (mon_en && row_read && !row_t2)
    begin
      if (have_prev)
      begin
        // rows 0..3 of 8 are read; a tick is 20 ref clocks, 2 with the pll
        slot = (prev < 3 ? 1 : 8 - prev) * (cfg_in.pll_enable ? 80 : 800);
        cmp("row order", 24'((prev + 1) % 4), row_read_addr);
        cmp_n("row spacing", slot, gap);
      end
      have_prev = 1;
      prev = row_read_addr;
      gap = 0;
    end
    if (mon_en && row_read && row_reset)
      cmp("reset row", 24'((row_read_addr + (row_t2 ? 1 : 3)) % 8), row_reset_addr);
    if (mon_en && row_read && row_t2)
      t2_reads++;
  end
  task automatic do_reset(input logic sel);
    @(negedge ref_clk);
    rstn = 0;
    bus_address_select = sel;
    mon_en = 0;
    have_prev = 0;
    adc_en = 0;
    repeat (5) @(negedge ref_clk);
    rstn = 1;
    repeat (5) @(negedge ref_clk);
    shut_seen = 0;
    t2_reads = 0;
    sent.delete();
    got.delete();
  endtask
  task automatic hit(input logic [7:0] b, input logic e);
    @(negedge ref_clk);
    bus_addr_byte = b;
    #1;
    cmp("address hit", e, bus_addr_hit);
  endtask
  // address select latched at reset release, defaults restored
  task automatic t_addr();
    do_reset(0);
    cmp("gain default", `SIR_AGAIN_ONE, analog_gain);
    cmp("offset default", `SIR_OFFSET_DEF, analog_offset);
    cmp("common mode default", 0, driver_high_common_mode);
    hit(8'h20, 1);
    hit(8'h21, 1);
    hit(8'h40, 0);
    hit(8'h30, 0);
    do_reset(1);
    bus_address_select = 0;
    repeat (4) @(negedge ref_clk);
    hit(8'h31, 1);
    hit(8'h20, 0);
    bus_addr_byte = 8'h00;
  endtask
  task automatic load(input logic par, input logic hdr);
    cfg_in = '0;
    cfg_in.hdr_enable = hdr;
    cfg_in.pll_enable = par; // parallel run uses the divided clock
    cfg_in.parallel_mode = par;
    cfg_in.shutter_enable = 1;
    cfg_in.driver_high_common_mode = 1;
    cfg_in.frame_rows = 12'd8;
    cfg_in.active_rows = 12'd4;
    cfg_in.line_pixels = 12'd8;
    cfg_in.row_ticks = 12'd40;
    cfg_in.exposure_rows = 12'd3;
    cfg_in.t2_rows = 12'd1;
    cfg_in.analog_gain = 8'h2c;
    cfg_in.analog_offset = 12'h05a;
    // serial at unity gain and no black, parallel with gain 2 to reach clipping
    cfg_in.black_level = par ? 12'h010 : 12'h000;
    cfg_in.digital_gain = par ? 8'h40 : `SIR_DGAIN_ONE;
    cfg_load = 1;
    @(negedge ref_clk);
    cfg_load = 0;
    par_mode = par;
    mon_en = 1;
    adc_en = 1;
    cmp("analog gain", 24'(cfg_in.analog_gain), analog_gain);
    cmp("analog offset", 24'(cfg_in.analog_offset), analog_offset);
    cmp("common mode", 1, driver_high_common_mode);
  endtask
  task automatic wait_pairs(input int n);
    int i;
    i = 0;
    while (got.size() < n)
    begin
      @(negedge ref_clk);
      i++;
      if (i > 30000)
      begin
        cmp_n("pairs received", n, got.size());
        complete_run();
      end
    end
  endtask
  // stream pairs, stop the feed, drain, compare with processed samples
  task automatic t_data();
    wait_pairs(12);
    adc_en = 0;
    repeat (3000) @(negedge ref_clk);
    cmp_n("pair count", sent.size() / 2, got.size());
    foreach (got[i])
      cmp("pixel pair", {proc(sent[2 * i + 1]), proc(sent[2 * i])}, got[i]);
  endtask
  task automatic t_serial();
    logic [8:0] acc;
    do_reset(0);
    load(0, 0);
    t_data();
    cmp("shutter seen", 1, shut_seen);
    cmp_n("lane faults", 0, bad_cnt);
    adc_en = 1;
    output_enable_n = 1;
    repeat (4) @(negedge ref_clk);
    acc = '0;
    repeat (200)
    begin
      @(negedge ref_clk);
      acc |= {serial_lane_pos, serial_lane_neg, shutter};
    end
    cmp("pins while disabled", 0, acc);
    output_enable_n = 0;
  endtask
  task automatic t_parallel();
    do_reset(0);
    load(1, 1);
    t_data();
    cmp_n("second exposure reads", 1, int'(t2_reads > 0));
    cmp_n("second exposure pixels", 1, int'(t2_cnt > 0));
    cmp_n("marker faults", 0, bad_cnt);
    adc_en = 1;
    wait_pairs(got.size() + 2);
    rstn = 0;
    #1;
    cmp("outputs in reset", 0, {frame_valid, line_valid, pixel_clock, par_data, shutter});
  endtask
  initial
  begin
    rstn = 0;
    bus_address_select = 0;
    output_enable_n = 0;
    bus_addr_byte = 8'h00;
    cfg_in = '0;
    cfg_load = 0;
    adc_data = 12'h007;
    adc_valid = 0;
    adc_en = 0;
    take = 0;
    par_mode = 0;
    mon_en = 0;
    have_prev = 0;
    shut_seen = 0;
    gap = 0;
    prev = 0;
    t2_reads = 0;
    error_cnt = 0;
    samples_checked = 0;
    repeat (5) @(negedge ref_clk);
    t_addr();
    t_serial();
    t_parallel();
    complete_run();
  end
endmodule
